// ### clc_consts.svh
`ifndef CLC_CONSTS_SVH
`define CLC_CONSTS_SVH

// Register byte offsets
`define CLC_OFF_CTRL    8'h00
`define CLC_OFF_CFG     8'h04
`define CLC_OFF_STAT    8'h08
`define CLC_OFF_LAT1    8'h0c
`define CLC_OFF_LAT2    8'h10

// Field widths and reset values
`define CLC_CTRL_W      5
`define CLC_CFG_W       4
`define CLC_STAT_W      6
`define CLC_CTRL_RST    5'h00
`define CLC_CFG_RST     4'h0

// Status bit positions
`define CLC_ST_ZP_VAL   0
`define CLC_ST_EXT_VAL  1
`define CLC_ST_SH_VAL   2
`define CLC_ST_EXT_LVL  3
`define CLC_ST_SH_LVL   4
`define CLC_ST_LOCKED   5

// Gate polarity codes
`define CLC_GATE_OFF    2'h0
`define CLC_GATE_POS    2'h1
`define CLC_GATE_NEG    2'h2
`define CLC_CFG_GATE_LSB 2

`endif

// ### clc_pkg.sv
package clc_pkg;

   // Capture enables, bit 0 is zp_en
   typedef struct packed {
      logic sh_neg;
      logic sh_pos;
      logic ext_neg;
      logic ext_pos;
      logic zp_en;
   } clc_ctrl_t;

   // Configuration, bit 0 is cont_ext
   typedef struct packed {
      logic [1:0] gate_pol;
      logic       cont_sh;
      logic       cont_ext;
   } clc_cfg_t;

   // Synchronised pin group, bit 0 is ext
   typedef struct packed {
      logic zero;
      logic shared;
      logic ext;
   } clc_pins_t;

   typedef enum logic [2:0] {
      w1_armed = 3'h1,
      w1_cont  = 3'h2,
      w1_held  = 3'h4
   } clc_w1_state_t;

endpackage : clc_pkg

// ### clc_top.sv
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "clc_consts.svh"

// Notes on behaviour
// - Rising external edge stores counter in word one
// - Falling external edge stores counter in word one
// - Both enables: either external edge captures
// - One-shot mode holds word one until cleared
// - Continuous mode overwrites word one every edge
// - External capture sets external valid flag
// - External pin level readable in status
// - Continuous plus zero pulse: first event only
// - Word one re-arms after all enables cleared
// - Rising shared edge stores counter in word two
// - Falling shared edge stores counter in word two
// - Both enables: either shared edge captures
// - One-shot mode holds word two while valid
// - Continuous mode overwrites word two every edge
// - Shared capture sets second valid flag
// - Shared pin level readable in status
// - Gate edge captures first, then locks counter
// - Zero pulse captures once, sets its flag
// - Zero pulse re-arms after enable, flag clear
// - Earliest set command owns word one
module clc_top #(
   parameter int CNT_W = 32
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic [CNT_W-1:0] counter_value,
   input  wire logic             ext_pin,
   input  wire logic             shared_pin,
   input  wire logic             zero_pin,
   output logic                  counter_lock
);

   generate
      if (CNT_W < 1 || CNT_W > 32)
      begin : g_bad_width
         $error("clc_top: CNT_W must be 1 to 32");
      end
   endgenerate

   clc_pkg::clc_ctrl_t     ctrl_r;
   clc_pkg::clc_cfg_t      cfg_r;
   clc_pkg::clc_pins_t     meta_r;
   clc_pkg::clc_pins_t     sync_r;
   clc_pkg::clc_pins_t     prev_r;
   clc_pkg::clc_pins_t     rise;
   clc_pkg::clc_pins_t     fall;
   clc_pkg::clc_w1_state_t w1_r;
   clc_pkg::clc_w1_state_t w1_nxt;
   logic [CNT_W-1:0]       latch1_r;
   logic [CNT_W-1:0]       latch2_r;
   logic                   ext_valid_r;
   logic                   zp_valid_r;
   logic                   sh_valid_r;
   logic                   owner_ext_r;
   logic                   owner_zp_r;
   logic                   lock_r;
   logic                   ext_en;
   logic                   sh_en;
   logic                   w1_any;
   logic                   ext_hit;
   logic                   zp_hit;
   logic                   sh_hit;
   logic                   ext_take;
   logic                   zp_take;
   logic                   sh_take;
   logic                   addr_ok;
   logic                   wr_en;
   logic                   rd_setup;
   logic [`CLC_STAT_W-1:0] stat;
   logic [31:0]            rd_val;

   // Three flops per pin; edges come from the second and third
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end
      else
      begin
         meta_r <= {zero_pin, shared_pin, ext_pin};
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;

   assign ext_en = ctrl_r.ext_pos | ctrl_r.ext_neg;
   assign sh_en  = ctrl_r.sh_pos | ctrl_r.sh_neg;
   assign w1_any = ext_en | ctrl_r.zp_en;

   assign ext_hit = (ctrl_r.ext_pos & rise.ext)
                  | (ctrl_r.ext_neg & fall.ext);
   assign zp_hit  = ctrl_r.zp_en & rise.zero;
   assign sh_hit  = (ctrl_r.sh_pos & rise.shared)
                  | (ctrl_r.sh_neg & fall.shared);

   // Continuous capture only while no zero-pulse command competes
   assign ext_take = ext_hit & ~owner_zp_r
                   & ((w1_r == clc_pkg::w1_armed)
                   | ((w1_r == clc_pkg::w1_cont)
                      & cfg_r.cont_ext & ~ctrl_r.zp_en));
   assign zp_take  = zp_hit & ~owner_ext_r
                   & (w1_r == clc_pkg::w1_armed);
   assign sh_take  = sh_hit & (cfg_r.cont_sh | ~sh_valid_r);

   // First command set claims word one; a tie goes to the first event
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         owner_ext_r <= 1'b0;
         owner_zp_r  <= 1'b0;
      end
      else if (!w1_any)
      begin
         owner_ext_r <= 1'b0;
         owner_zp_r  <= 1'b0;
      end
      else if (!owner_ext_r && !owner_zp_r)
      begin
         owner_ext_r <= ext_en & ~ctrl_r.zp_en;
         owner_zp_r  <= ctrl_r.zp_en & ~ext_en;
      end
   end

   always_comb
   begin
      w1_nxt = w1_r;
      unique case (w1_r)
         clc_pkg::w1_armed:
         begin
            if (ext_take && cfg_r.cont_ext && !ctrl_r.zp_en)
               w1_nxt = clc_pkg::w1_cont;
            else if (ext_take || zp_take)
               w1_nxt = clc_pkg::w1_held;
         end
         clc_pkg::w1_cont:
         begin
            if (!w1_any)
               w1_nxt = clc_pkg::w1_armed;
            else if (!cfg_r.cont_ext || ctrl_r.zp_en)
               w1_nxt = clc_pkg::w1_held;
         end
         clc_pkg::w1_held:
         begin
            if (!w1_any)
               w1_nxt = clc_pkg::w1_armed;
         end
         default:
            w1_nxt = clc_pkg::w1_held;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         w1_r <= clc_pkg::w1_armed;
      else
         w1_r <= w1_nxt;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         latch1_r <= '0;
      else if (ext_take || zp_take)
         latch1_r <= counter_value;
   end

   // Set beats clear; flags drop when their own enables drop
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_valid_r <= 1'b0;
         zp_valid_r  <= 1'b0;
      end
      else
      begin
         if (ext_take)
            ext_valid_r <= 1'b1;
         else if (!ext_en)
            ext_valid_r <= 1'b0;
         if (zp_take && !ext_take)
            zp_valid_r <= 1'b1;
         else if (!ctrl_r.zp_en)
            zp_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         latch2_r   <= '0;
         sh_valid_r <= 1'b0;
      end
      else if (sh_take)
      begin
         latch2_r   <= counter_value;
         sh_valid_r <= 1'b1;
      end
      else if (!sh_en)
         sh_valid_r <= 1'b0;
   end

   // Capture uses this cycle's count; lock shows from the next one
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lock_r <= 1'b0;
      else if (cfg_r.gate_pol == `CLC_GATE_OFF)
         lock_r <= 1'b0;
      else if ((cfg_r.gate_pol == `CLC_GATE_POS && rise.shared)
            || (cfg_r.gate_pol == `CLC_GATE_NEG && fall.shared))
         lock_r <= 1'b1;
   end

   assign counter_lock = lock_r;

   assign addr_ok  = (paddr == `CLC_OFF_CTRL) || (paddr == `CLC_OFF_CFG)
                  || (paddr == `CLC_OFF_STAT) || (paddr == `CLC_OFF_LAT1)
                  || (paddr == `CLC_OFF_LAT2);
   assign wr_en    = psel & penable & pwrite & addr_ok;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & ~addr_ok;

   assign stat = {lock_r, sync_r.shared, sync_r.ext,
                  sh_valid_r, ext_valid_r, zp_valid_r};

   always_comb
   begin
      rd_val = 32'h0000_0000;
      unique case (paddr)
         `CLC_OFF_CTRL: rd_val[`CLC_CTRL_W-1:0] = ctrl_r;
         `CLC_OFF_CFG:  rd_val[`CLC_CFG_W-1:0]  = cfg_r;
         `CLC_OFF_STAT: rd_val[`CLC_STAT_W-1:0] = stat;
         `CLC_OFF_LAT1: rd_val[CNT_W-1:0]       = latch1_r;
         `CLC_OFF_LAT2: rd_val[CNT_W-1:0]       = latch2_r;
         default:       rd_val                  = 32'h0000_0000;
      endcase
   end

   // Read data sampled in setup so access needs no wait state
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
         prdata <= rd_val;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= `CLC_CTRL_RST;
         cfg_r  <= `CLC_CFG_RST;
      end
      else if (wr_en)
      begin
         if (paddr == `CLC_OFF_CTRL)
            ctrl_r <= pwdata[`CLC_CTRL_W-1:0];
         if (paddr == `CLC_OFF_CFG)
            cfg_r <= pwdata[`CLC_CFG_W-1:0];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_ext_captured;
      ext_take ##1 (latch1_r == $past(counter_value)) && ext_valid_r;
   endsequence

   sequence s_stat_read;
      rd_setup && paddr == `CLC_OFF_STAT;
   endsequence

   a_ext_capture_value: assert property (ext_take |-> s_ext_captured)
      else $error("external capture did not store count and flag");
   a_ext_rise_take: assert property (w1_r == clc_pkg::w1_armed
      && ctrl_r.ext_pos && rise.ext && !owner_zp_r |-> ext_take)
      else $error("armed rising external edge not taken");
   a_ext_fall_take: assert property (w1_r == clc_pkg::w1_armed
      && ctrl_r.ext_neg && fall.ext && !owner_zp_r |-> ext_take)
      else $error("armed falling external edge not taken");
   a_ext_both_edges: assert property (w1_r == clc_pkg::w1_armed
      && ctrl_r.ext_pos && ctrl_r.ext_neg && !owner_zp_r
      && (rise.ext || fall.ext) |-> ext_take)
      else $error("edge missed with both enables");
   a_word1_held: assert property (w1_r == clc_pkg::w1_held && w1_any
      |=> $stable(latch1_r))
      else $error("word one changed while held");
   a_ext_continuous: assert property (w1_r == clc_pkg::w1_cont
      && ext_hit && cfg_r.cont_ext && !ctrl_r.zp_en |-> ext_take)
      else $error("continuous edge not taken");
   a_ext_level_read: assert property (s_stat_read
      |=> prdata[`CLC_ST_EXT_LVL] == $past(sync_r.ext))
      else $error("external level wrong in status");
   a_first_event_only: assert property (ctrl_r.zp_en
      && (ext_take || zp_take) |=> w1_r == clc_pkg::w1_held)
      else $error("word one not held after first event");
   a_word1_rearm: assert property (w1_r == clc_pkg::w1_held
      && w1_any |=> w1_r != clc_pkg::w1_armed)
      else $error("word one re-armed with an enable set");
   a_sh_capture: assert property (sh_take
      |=> latch2_r == $past(counter_value) && sh_valid_r)
      else $error("shared capture did not store count and flag");
   a_sh_oneshot: assert property (sh_valid_r && !cfg_r.cont_sh
      |-> !sh_take)
      else $error("word two overwritten in one-shot mode");
   a_sh_level_read: assert property (s_stat_read
      |=> prdata[`CLC_ST_SH_LVL] == $past(sync_r.shared))
      else $error("shared level wrong in status");
   a_gate_lock: assert property (cfg_r.gate_pol == `CLC_GATE_POS
      && rise.shared && ctrl_r.sh_pos && !sh_valid_r
      |=> lock_r && latch2_r == $past(counter_value))
      else $error("gate edge did not capture then lock");
   a_zp_once: assert property (zp_valid_r && ctrl_r.zp_en
      |-> !zp_take)
      else $error("zero pulse retaken while valid");
   a_owner_blocks: assert property (owner_ext_r |-> !zp_take)
      else $error("later zero-pulse command took word one");
   a_pin_sync: assert property ($stable(ext_pin) [*3]
      |-> sync_r.ext == ext_pin)
      else $error("external pin not synchronised in two cycles");

endmodule : clc_top

// ### clc_enc_model.sv
`timescale 1ns/1ps
module clc_enc_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        counter_lock,
   output logic      [31:0] counter_value,
   output logic             ext_pin,
   output logic             shared_pin,
   output logic             zero_pin
);
   logic [31:0] cnt_r;
   assign counter_value = cnt_r;
   // Encoder count stops while the gate holds it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_r <= 32'h0;
      else if (!counter_lock)
         cnt_r <= cnt_r + 32'h1;
   end
   initial
   begin
      ext_pin = 1'b0;
      shared_pin = 1'b0;
      zero_pin = 1'b0;
   end
   // Two sync stages plus the capture edge put the stored count 3 ahead
   task automatic set_pin(input int p, input logic v, output logic [31:0] e);
      @(posedge pclk);
      e = cnt_r + 32'h3;
      case (p)
         0: ext_pin <= v;
         1: shared_pin <= v;
         default: zero_pin <= v;
      endcase
   endtask : set_pin
endmodule : clc_enc_model

// ### testbench.sv
`timescale 1ns/1ps
`include "clc_consts.svh"
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, counter_value, q, e;
   logic        pready, pslverr, counter_lock;
   logic        ext_pin, shared_pin, zero_pin;
   logic [31:0] last [2];
   int          n_fail, checks;

   clc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .counter_value(counter_value), .ext_pin(ext_pin),
      .shared_pin(shared_pin), .zero_pin(zero_pin),
      .counter_lock(counter_lock));
   clc_enc_model i_enc (.pclk(pclk), .presetn(presetn),
      .counter_lock(counter_lock), .counter_value(counter_value),
      .ext_pin(ext_pin), .shared_pin(shared_pin), .zero_pin(zero_pin));

   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No cap here: only the watchdog may end a stuck access
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic sbit(input int b, input logic x);
      apb(1'b0, `CLC_OFF_STAT, 32'h0);
      chk(32'(q[b]), 32'(x));
   endtask : sbit

   task automatic t_reset;
      apb(1'b1, `CLC_OFF_STAT, 32'hffff_ffff);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(q, 32'h0);
      end
      apb(1'b0, 8'h14, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(q, 32'h0);
   endtask : t_reset

   // Rise then fall on one pin under a given enable and mode
   task automatic edges(input int p, input logic [4:0] m,
                        input logic [3:0] cf);
      logic [7:0]  la;
      logic [31:0] r;
      la = p ? `CLC_OFF_LAT2 : `CLC_OFF_LAT1;
      apb(1'b1, `CLC_OFF_CFG, {28'h0, cf});
      apb(1'b1, `CLC_OFF_CTRL, {27'h0, m});
      i_enc.set_pin(p, 1'b1, r);
      repeat (4) @(posedge pclk);
      if (m[1 + 2 * p])
         last[p] = r;
      apb(1'b0, la, 32'h0);
      chk(q, last[p]);
      sbit(3 + p, 1'b1);
      i_enc.set_pin(p, 1'b0, r);
      repeat (4) @(posedge pclk);
      if (m[2 + 2 * p] && (cf[p] || !m[1 + 2 * p]))
         last[p] = r;
      apb(1'b0, la, 32'h0);
      chk(q, last[p]);
      sbit(1 + p, 1'b1);
      sbit(3 + p, 1'b0);
      apb(1'b1, `CLC_OFF_CTRL, 32'h0);
      sbit(1 + p, 1'b0);
   endtask : edges

   task automatic zpulse(output logic [31:0] r);
      i_enc.set_pin(2, 1'b1, r);
      i_enc.set_pin(2, 1'b0, e);
      repeat (4) @(posedge pclk);
   endtask : zpulse

   task automatic t_zero;
      logic [31:0] r;
      apb(1'b1, `CLC_OFF_CTRL, 32'h1);
      zpulse(r);
      apb(1'b0, `CLC_OFF_LAT1, 32'h0);
      chk(q, r);
      sbit(0, 1'b1);
      zpulse(e);
      apb(1'b0, `CLC_OFF_LAT1, 32'h0);
      chk(q, r);
      apb(1'b1, `CLC_OFF_CTRL, 32'h0);
      sbit(0, 1'b0);
      apb(1'b1, `CLC_OFF_CFG, 32'h1);
      apb(1'b1, `CLC_OFF_CTRL, 32'h3);
      zpulse(r);
      i_enc.set_pin(0, 1'b1, e);
      repeat (4) @(posedge pclk);
      apb(1'b0, `CLC_OFF_LAT1, 32'h0);
      chk(q, r);
      sbit(0, 1'b1);
      sbit(1, 1'b0);
      apb(1'b1, `CLC_OFF_CTRL, 32'h0);
      apb(1'b1, `CLC_OFF_CFG, 32'h0);
      // Edge enable set first, zero enable joins later
      apb(1'b1, `CLC_OFF_CTRL, 32'h2);
      apb(1'b1, `CLC_OFF_CTRL, 32'h3);
      zpulse(e);
      sbit(0, 1'b0);
      i_enc.set_pin(0, 1'b0, e);
      i_enc.set_pin(0, 1'b1, r);
      repeat (4) @(posedge pclk);
      apb(1'b0, `CLC_OFF_LAT1, 32'h0);
      chk(q, r);
      sbit(1, 1'b1);
      apb(1'b1, `CLC_OFF_CTRL, 32'h0);
   endtask : t_zero

   task automatic t_gate;
      logic [31:0] r;
      logic [31:0] c;
      for (int g = 1; g < 3; g++)
      begin
         apb(1'b1, `CLC_OFF_CFG, 32'(g) << `CLC_CFG_GATE_LSB);
         apb(1'b1, `CLC_OFF_CTRL, 32'(4 << g));
         i_enc.set_pin(1, g == 1, r);
         repeat (4) @(posedge pclk);
         chk({31'h0, counter_lock}, 32'h1);
         c = counter_value;
         apb(1'b0, `CLC_OFF_LAT2, 32'h0);
         chk(q, r);
         chk(counter_value, c);
         sbit(5, 1'b1);
         apb(1'b1, `CLC_OFF_CFG, 32'h0);
         apb(1'b1, `CLC_OFF_CTRL, 32'h0);
         sbit(5, 1'b0);
      end
   endtask : t_gate

   task automatic end_sim;
      $display("Checks %0d, failures %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      n_fail = 0;
      checks = 0;
      last[0] = 32'h0;
      last[1] = 32'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      for (int p = 0; p < 2; p++)
      begin
         for (int m = 1; m < 4; m++)
            edges(p, 5'(2 * m) << (2 * p), 4'h0);
         edges(p, 5'h06 << (2 * p), 4'h1 << p);
      end
      t_zero;
      t_gate;
      end_sim;
   end

   // Whole run is a few hundred cycles
   initial
   begin
      #200000;
      n_fail++;
      end_sim;
   end
endmodule : testbench
